// ---- pkg/mic_pkg.sv ----
// Package of register offsets, field positions and reset values for the interrupt control.
package mic_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] MIC_OFS_SOURCE = 8'h0C;
  localparam logic [7:0] MIC_OFS_WAKE_PIN_CTRL = 8'h2C;
  localparam logic [7:0] MIC_OFS_IRQ_ENABLE = 8'h2D;
  localparam logic [7:0] MIC_OFS_IRQ_ROUTING = 8'h2E;

  // ****************************************************************
  // Field positions of the wake and pin control register
  // ****************************************************************
  localparam int MIC_BIT_FIFO_GATE = 7;
  localparam int MIC_BIT_TRANSIENT_WAKE = 6;
  localparam int MIC_BIT_ORIENTATION_WAKE = 5;
  localparam int MIC_BIT_PULSE_WAKE = 4;
  localparam int MIC_BIT_FALL_MOTION_WAKE = 3;
  localparam int MIC_BIT_IRQ_POLARITY = 1;
  localparam int MIC_BIT_IRQ_DRIVE_SELECT = 0;

  // ****************************************************************
  // Source positions, shared by enable, routing and source registers
  // ****************************************************************
  localparam int MIC_SRC_AUTOSLEEP = 7;
  localparam int MIC_SRC_FIFO = 6;
  localparam int MIC_SRC_TRANSIENT = 5;
  localparam int MIC_SRC_ORIENTATION = 4;
  localparam int MIC_SRC_PULSE = 3;
  localparam int MIC_SRC_FALL_MOTION = 2;
  localparam int MIC_SRC_SAMPLE_READY = 0;

  // ****************************************************************
  // Writable masks and reset values
  // ****************************************************************
  localparam logic [7:0] MIC_MASK_WAKE_PIN_CTRL = 8'hFB;
  localparam logic [7:0] MIC_MASK_SOURCES = 8'hFD;
  localparam logic [7:0] MIC_RST_WAKE_PIN_CTRL = 8'h00;
  localparam logic [7:0] MIC_RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] MIC_RST_IRQ_ROUTING = 8'h00;
  localparam logic [7:0] MIC_RST_READ_DATA = 8'h00;

endpackage

// ---- design/mic_top.sv ----
// Interrupt, wake and pin control of a three-axis motion sensor.
//
// Notes on behaviour
// R1 - Transient wake bit 6 set lets transient events wake; clear bypasses them in sleep.
// R2 - Orientation wake bit 5 set lets orientation events wake; clear bypasses them.
// R3 - Pulse wake bit 4 set lets pulse events wake; clear bypasses them.
// R4 - Fall/motion wake bit set lets fall/motion events wake; clear, reset, bypasses.
// R5 - Polarity bit 1 sets both pins' active level: 0 low, 1 high.
// R6 - Drive bit 0 selects push-pull when 0, open-drain when 1.
// R7 - Enable register holds seven source enables at bits 7..2 and 0.
// R8 - Each enable bit resets to 0, disabling; 1 enables its source.
// R9 - Only enabled sources pass their event flags to the pin logic.
// R10 - Routing bit 0 sends a source to pin two, 1 to pin one.
// R11 - Host reads the source register at 0x0C to learn active sources.
// R12 - A pin asserts while any enabled source routed to it is flagged.
// R13 - Reserved control bit 2 and enable bit 1 read zero, ignore writes.

`timescale 1ns/10ps
`default_nettype none

module mic_top #(
  parameter int REG_W = 8
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic soft_reset,
  // Register port from the two-wire bus engine.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [REG_W-1:0] reg_rdata,
  // Event flags of the detection functions and the system sleep state.
  input wire logic [REG_W-1:0] event_flags,
  input wire logic sleep_mode,
  output logic wake_request,
  // Interrupt pins, as output level and output enable.
  output logic irq_pin_one_out,
  output logic irq_pin_one_oe,
  output logic irq_pin_two_out,
  output logic irq_pin_two_oe
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (REG_W != 8) begin : g_width_check
    $error("mic_top serves only an eight-bit register width.");
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [REG_W-1:0] wake_pin_ctrl_q;
  logic [REG_W-1:0] wake_pin_ctrl_d;
  logic [REG_W-1:0] irq_enable_q;
  logic [REG_W-1:0] irq_enable_d;
  logic [REG_W-1:0] irq_routing_q;
  logic [REG_W-1:0] irq_routing_d;
  logic [REG_W-1:0] rdata_q;
  logic [REG_W-1:0] rdata_d;
  logic [REG_W-1:0] active_src;

  always_comb begin
    wake_pin_ctrl_d = wake_pin_ctrl_q;
    irq_enable_d = irq_enable_q;
    irq_routing_d = irq_routing_q;
    rdata_d = rdata_q;
    if (soft_reset) begin
      // Software reset returns every register to its default.
      wake_pin_ctrl_d = mic_pkg::MIC_RST_WAKE_PIN_CTRL;
      irq_enable_d = mic_pkg::MIC_RST_IRQ_ENABLE; // R8
      irq_routing_d = mic_pkg::MIC_RST_IRQ_ROUTING;
      rdata_d = mic_pkg::MIC_RST_READ_DATA;
    end else begin
      if (reg_wr_en) begin
        case (reg_addr)
          mic_pkg::MIC_OFS_WAKE_PIN_CTRL: begin
            wake_pin_ctrl_d = reg_wdata & mic_pkg::MIC_MASK_WAKE_PIN_CTRL; // R13
          end
          mic_pkg::MIC_OFS_IRQ_ENABLE: begin
            irq_enable_d = reg_wdata & mic_pkg::MIC_MASK_SOURCES; // R7 R13
          end
          mic_pkg::MIC_OFS_IRQ_ROUTING: begin
            irq_routing_d = reg_wdata & mic_pkg::MIC_MASK_SOURCES;
          end
          default: begin
            wake_pin_ctrl_d = wake_pin_ctrl_q;
          end
        endcase
      end
      if (reg_rd_en) begin
        case (reg_addr)
          mic_pkg::MIC_OFS_SOURCE: begin
            rdata_d = active_src; // R11
          end
          mic_pkg::MIC_OFS_WAKE_PIN_CTRL: begin
            rdata_d = wake_pin_ctrl_q;
          end
          mic_pkg::MIC_OFS_IRQ_ENABLE: begin
            rdata_d = irq_enable_q;
          end
          mic_pkg::MIC_OFS_IRQ_ROUTING: begin
            rdata_d = irq_routing_q;
          end
          default: begin
            rdata_d = mic_pkg::MIC_RST_READ_DATA;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wake_pin_ctrl_q <= mic_pkg::MIC_RST_WAKE_PIN_CTRL;
      irq_enable_q <= mic_pkg::MIC_RST_IRQ_ENABLE;
      irq_routing_q <= mic_pkg::MIC_RST_IRQ_ROUTING;
      rdata_q <= mic_pkg::MIC_RST_READ_DATA;
    end else if (clk_en) begin
      wake_pin_ctrl_q <= wake_pin_ctrl_d;
      irq_enable_q <= irq_enable_d;
      irq_routing_q <= irq_routing_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************************************
  // Source gating, routing and wake selection
  // ****************************************************************
  logic [REG_W-1:0] wake_sel;
  logic any_one;
  logic any_two;
  logic wake_hit;

  always_comb begin
    // A source whose enable is clear never reaches a pin.
    active_src = event_flags & irq_enable_q & mic_pkg::MIC_MASK_SOURCES; // R9
    any_one = |(active_src & irq_routing_q); // R10 R12
    any_two = |(active_src & ~irq_routing_q); // R10 R12
    wake_sel = '0;
    wake_sel[mic_pkg::MIC_SRC_TRANSIENT] =
      wake_pin_ctrl_q[mic_pkg::MIC_BIT_TRANSIENT_WAKE]; // R1
    wake_sel[mic_pkg::MIC_SRC_ORIENTATION] =
      wake_pin_ctrl_q[mic_pkg::MIC_BIT_ORIENTATION_WAKE]; // R2
    wake_sel[mic_pkg::MIC_SRC_PULSE] =
      wake_pin_ctrl_q[mic_pkg::MIC_BIT_PULSE_WAKE]; // R3
    wake_sel[mic_pkg::MIC_SRC_FALL_MOTION] =
      wake_pin_ctrl_q[mic_pkg::MIC_BIT_FALL_MOTION_WAKE]; // R4
    // In sleep, functions without their wake bit are bypassed.
    wake_hit = sleep_mode && (|(active_src & wake_sel)); // R1 R2 R3 R4
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic pin_one_out_q;
  logic pin_one_out_d;
  logic pin_one_oe_q;
  logic pin_one_oe_d;
  logic pin_two_out_q;
  logic pin_two_out_d;
  logic pin_two_oe_q;
  logic pin_two_oe_d;
  logic wake_q;
  logic wake_d;
  logic polarity;
  logic open_drain;
  logic level_one;
  logic level_two;

  always_comb begin
    polarity = wake_pin_ctrl_q[mic_pkg::MIC_BIT_IRQ_POLARITY];
    open_drain = wake_pin_ctrl_q[mic_pkg::MIC_BIT_IRQ_DRIVE_SELECT];
    // Asserted pins take the polarity level, idle pins its inverse.
    level_one = any_one ? polarity : ~polarity; // R5
    level_two = any_two ? polarity : ~polarity; // R5
    if (open_drain) begin
      // Open drain only pulls low, so a shared line can be wired.
      pin_one_out_d = 1'b0; // R6
      pin_one_oe_d = ~level_one; // R6
      pin_two_out_d = 1'b0;
      pin_two_oe_d = ~level_two;
    end else begin
      pin_one_out_d = level_one; // R6
      pin_one_oe_d = 1'b1;
      pin_two_out_d = level_two;
      pin_two_oe_d = 1'b1;
    end
    wake_d = wake_hit;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_one_out_q <= 1'b1;
      pin_one_oe_q <= 1'b1;
      pin_two_out_q <= 1'b1;
      pin_two_oe_q <= 1'b1;
      wake_q <= 1'b0;
    end else if (clk_en) begin
      pin_one_out_q <= pin_one_out_d;
      pin_one_oe_q <= pin_one_oe_d;
      pin_two_out_q <= pin_two_out_d;
      pin_two_oe_q <= pin_two_oe_d;
      wake_q <= wake_d;
    end
  end

  assign irq_pin_one_out = pin_one_out_q;
  assign irq_pin_one_oe = pin_one_oe_q;
  assign irq_pin_two_out = pin_two_out_q;
  assign irq_pin_two_oe = pin_two_oe_q;
  assign wake_request = wake_q;

endmodule

`default_nettype wire

// ---- verif/mic_sva.sv ----
// Checker of the interrupt control ports.
`timescale 1ns/10ps
`default_nettype none
module mic_sva #(
  parameter int REG_W = 8
) (
  // Clock, reset and bus.
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic soft_reset,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic [REG_W-1:0] reg_rdata,
  input wire logic [REG_W-1:0] event_flags,
  // Sleep and pins.
  input wire logic sleep_mode,
  input wire logic wake_request,
  input wire logic irq_pin_one_out,
  input wire logic irq_pin_one_oe,
  input wire logic irq_pin_two_out,
  input wire logic irq_pin_two_oe
);
  logic [7:0] c_q, e_q, r_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Shadow copies of the three writable registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {c_q, e_q, r_q} <= '0;
    end else if (clk_en && soft_reset) begin
      {c_q, e_q, r_q} <= '0;
    end else if (clk_en && reg_wr_en) begin
      if (reg_addr == mic_pkg::MIC_OFS_WAKE_PIN_CTRL) c_q <= reg_wdata & 8'hFB;
      if (reg_addr == mic_pkg::MIC_OFS_IRQ_ENABLE) e_q <= reg_wdata & 8'hFD;
      if (reg_addr == mic_pkg::MIC_OFS_IRQ_ROUTING) r_q <= reg_wdata & 8'hFD;
    end
  end
  // Returns the output enable of one pin when oe is high, its level otherwise.
  function automatic logic pin(logic [7:0] c, e, r, f, logic one, logic oe);
    logic v;
    v = |(f & e & 8'hFD & (one ? r : ~r)) ? c[1] : ~c[1];
    if (oe) return c[0] ? ~v : 1'b1;
    return c[0] ? 1'b0 : v;
  endfunction
  function automatic logic [7:0] rdv(logic [7:0] a, c, e, r, f);
    case (a)
      mic_pkg::MIC_OFS_SOURCE: return f & e & 8'hFD;
      mic_pkg::MIC_OFS_WAKE_PIN_CTRL: return c;
      mic_pkg::MIC_OFS_IRQ_ENABLE: return e;
      mic_pkg::MIC_OFS_IRQ_ROUTING: return r;
      default: return 8'h00;
    endcase
  endfunction
  chk_pin_one_out:
    assert property ($past(clk_en) |-> irq_pin_one_out ==
      pin($past(c_q), $past(e_q), $past(r_q), $past(event_flags), 1'b1, 1'b0))
    else $error("pin one level wrong");
  chk_pin_one_oe:
    assert property ($past(clk_en) |-> irq_pin_one_oe ==
      pin($past(c_q), $past(e_q), $past(r_q), $past(event_flags), 1'b1, 1'b1))
    else $error("pin one enable wrong");
  chk_pin_two_out:
    assert property ($past(clk_en) |-> irq_pin_two_out ==
      pin($past(c_q), $past(e_q), $past(r_q), $past(event_flags), 1'b0, 1'b0))
    else $error("pin two level wrong");
  chk_pin_two_oe:
    assert property ($past(clk_en) |-> irq_pin_two_oe ==
      pin($past(c_q), $past(e_q), $past(r_q), $past(event_flags), 1'b0, 1'b1))
    else $error("pin two enable wrong");
  chk_read_data:
    assert property ($past(clk_en && reg_rd_en && !soft_reset) |-> reg_rdata ==
      rdv($past(reg_addr), $past(c_q), $past(e_q), $past(r_q), $past(event_flags)))
    else $error("read data wrong");
  chk_rdata_hold:
    assert property (!$past(clk_en && (reg_rd_en || soft_reset)) |-> $stable(reg_rdata))
    else $error("read data moved");
  chk_wake_gate:
    assert property ($past(clk_en) |-> wake_request == ($past(sleep_mode) &&
      |($past(event_flags & e_q) & {2'b00, $past(c_q[6:3]), 2'b00})))
    else $error("wake request wrong");
  chk_freeze_all:
    assert property (!$past(clk_en) |-> $stable({irq_pin_one_out, irq_pin_one_oe,
      irq_pin_two_out, irq_pin_two_oe, wake_request}))
    else $error("outputs moved while frozen");
endmodule
bind mic_top mic_sva #(.REG_W(REG_W)) u_sva (.clk(clk), .nrst(nrst), .clk_en(clk_en),
  .soft_reset(soft_reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .event_flags(event_flags), .sleep_mode(sleep_mode), .wake_request(wake_request),
  .irq_pin_one_out(irq_pin_one_out), .irq_pin_one_oe(irq_pin_one_oe),
  .irq_pin_two_out(irq_pin_two_out), .irq_pin_two_oe(irq_pin_two_oe));
`default_nettype wire

// ---- verif/mic_host_model.sv ----
// Host side of the interrupt lines, each with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module mic_host_model (
  // Pin drive from the device.
  input wire logic one_out,
  input wire logic one_oe,
  input wire logic two_out,
  input wire logic two_oe,
  // Line levels seen by the host.
  output logic line_one,
  output logic line_two
);
  // A released open-drain line is pulled high.
  assign line_one = one_oe ? one_out : 1'b1;
  assign line_two = two_oe ? two_out : 1'b1;
endmodule
`default_nettype wire

// ---- verif/mic_tb_top.sv ----
// Testbench of the interrupt control.
`timescale 1ns/10ps
`default_nettype none
module mic_tb_top;
  logic clk = 0, nrst = 0, clk_en = 1, soft_reset = 0, reg_wr_en = 0, reg_rd_en = 0;
  logic sleep_mode = 0, wake, p1o, p1e, p2o, p2e, line_one, line_two;
  logic [7:0] reg_addr = 0, reg_wdata = 0, event_flags = 0, reg_rdata;
  int mismatches = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  mic_top #(.REG_W(8)) uut (.clk(clk), .nrst(nrst), .clk_en(clk_en),
    .soft_reset(soft_reset), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .event_flags(event_flags), .sleep_mode(sleep_mode), .wake_request(wake),
    .irq_pin_one_out(p1o), .irq_pin_one_oe(p1e), .irq_pin_two_out(p2o),
    .irq_pin_two_oe(p2e));
  mic_host_model host (.one_out(p1o), .one_oe(p1e), .two_out(p2o), .two_oe(p2e),
    .line_one(line_one), .line_two(line_two));
  task automatic cmp(string nm, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmp_lines(logic [1:0] exp, logic [1:0] oe);
    repeat (3) @(negedge clk);
    cmp("lines", {6'h00, exp}, {6'h00, line_one, line_two});
    cmp("enables", {6'h00, oe}, {6'h00, p1e, p2e});
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr_en} = {a, d, 1'b1};
    @(negedge clk);
    reg_wr_en = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clk);
    {reg_addr, reg_rd_en} = {a, 1'b1};
    @(negedge clk);
    reg_rd_en = 0;
    cmp("reg_rdata", exp, reg_rdata);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1;
    rd(8'h2C, 8'h00);
    rd(8'h2D, 8'h00);
    rd(8'h2E, 8'h00);
    rd(8'h10, 8'h00);
    cmp_lines(2'b11, 2'b11);
    $display("test reset done");
    wr(8'h2D, 8'hFF);
    rd(8'h2D, 8'hFD);
    rd(8'h10, 8'h00);
    wr(8'h2C, 8'hFF);
    rd(8'h2C, 8'hFB);
    wr(8'h0C, 8'hFF);
    rd(8'h2E, 8'h00);
    rd(8'h2C, 8'hFB);
    wr(8'h2C, 8'h00);
    wr(8'h2E, 8'hFF);
    rd(8'h2E, 8'hFD);
    wr(8'h2E, 8'h21);
    rd(8'h2E, 8'h21);
    $display("test registers done");
    event_flags = 8'h03;
    cmp_lines(2'b01, 2'b11);
    rd(8'h0C, 8'h01);
    event_flags = 8'h04;
    cmp_lines(2'b10, 2'b11);
    rd(8'h0C, 8'h04);
    wr(8'h2D, 8'hF9);
    cmp_lines(2'b11, 2'b11);
    wr(8'h2C, 8'h02);
    cmp_lines(2'b00, 2'b11);
    event_flags = 8'h01;
    cmp_lines(2'b10, 2'b11);
    wr(8'h2C, 8'h03);
    cmp_lines(2'b10, 2'b01);
    clk_en = 0;
    event_flags = 8'h00;
    cmp_lines(2'b10, 2'b01);
    clk_en = 1;
    cmp_lines(2'b00, 2'b11);
    $display("test pins done");
    wr(8'h2D, 8'hFD);
    sleep_mode = 1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h2C, 8'h40 >> i);
      event_flags = 8'h20 >> i;
      repeat (2) @(negedge clk);
      cmp("wake", 8'h01, {7'h00, wake});
      event_flags = (8'h20 >> i) ^ 8'h3C;
      repeat (2) @(negedge clk);
      cmp("wake", 8'h00, {7'h00, wake});
    end
    $display("test wake done");
    soft_reset = 1;
    @(negedge clk);
    soft_reset = 0;
    rd(8'h2D, 8'h00);
    rd(8'h2C, 8'h00);
    rd(8'h2E, 8'h00);
    cmp_lines(2'b11, 2'b11);
    $display("test soft reset done");
    close_out();
  end
endmodule
`default_nettype wire
